// *** core/spsc_top.sv ***
module spsc_top #(
  parameter spsc_pkg::spsc_role_type PORT_ROLE    = spsc_pkg::SPSC_ROLE_DOWN,
  parameter logic [1:0]              ASPM_SUPPORT = spsc_pkg::ASPM_L0S_L1
) (
  // Clock and reset
  input  wire logic        REF_CLK_I,
  input  wire logic        RESET_N_I,
  // Configuration access
  input  wire logic        CFG_WR_I,
  input  wire logic        CFG_RD_I,
  input  wire logic [7:0]  CFG_ADDR_I,
  input  wire logic [3:0]  CFG_BE_I,
  input  wire logic [31:0] CFG_WDATA_I,
  output logic      [31:0] CFG_RDATA_O,
  output logic             CFG_RVALID_O,
  // Serial EEPROM or I2C preload
  input  wire logic        LOAD_WR_I,
  input  wire logic [7:0]  LOAD_ADDR_I,
  input  wire logic [31:0] LOAD_WDATA_I,
  // Link state from the port logic
  input  wire logic [7:0]  FAST_TRAINING_SEQ_COUNT_I,
  input  wire logic        LINK_SPEED_5G_I,
  input  wire logic        DL_UP_I,
  // Received slot power limit message
  input  wire logic        SPL_RX_VALID_I,
  input  wire logic [7:0]  SPL_RX_VALUE_I,
  input  wire logic [1:0]  SPL_RX_SCALE_I,
  // Outgoing slot power limit message
  output logic             SPL_MSG_REQ_O,
  output logic [7:0]       SPL_MSG_VALUE_O,
  output logic [1:0]       SPL_MSG_SCALE_O,
  input  wire logic        SPL_MSG_ACK_I,
  // Slot pins and slot control
  input  wire logic        RETENTION_LATCH_I,
  input  wire logic        POWER_CONTROLLER_CONTROL_I,
  // Link power controls
  output logic             TX_L0S_ENABLE_O,
  output logic             L1_ENABLE_O,
  output logic             RX_L0S_PERMIT_O,
  output logic             REFCLK_REMOVE_OK_O,
  // Slot power control
  output logic             HOTPLUG_ENABLE_O,
  output logic             SLOT_POWER_ON_O
);

  generate
    if (ASPM_SUPPORT != spsc_pkg::ASPM_L0S_ONLY && ASPM_SUPPORT != spsc_pkg::ASPM_L0S_L1) begin : g_chk
      $error("ASPM_SUPPORT must be L0s only or L0s plus L1");
    end
    // A role code outside the enum would make every role gate treat the port as not downstream
    if (PORT_ROLE != spsc_pkg::SPSC_ROLE_UP && PORT_ROLE != spsc_pkg::SPSC_ROLE_DOWN
        && PORT_ROLE != spsc_pkg::SPSC_ROLE_NT) begin : g_role_chk
      $error("PORT_ROLE must be upstream, downstream or nontransparent");
    end
  endgenerate

  localparam bit IS_DOWN = (PORT_ROLE == spsc_pkg::SPSC_ROLE_DOWN);

  // Byte lanes that carry the select and the ASPM control
  localparam int BE_SEL_LANE   = 1;
  localparam int BE_ASPM_LANE  = 0;
  localparam int LCTL_ASPM_LSB = 0;

  spsc_caps_if caps ();

  // Latch pin synchroniser
  logic latch_meta;
  logic latch_sync;

  // Power data storage
  logic [3:0] pm_sel;
  logic       pm_sel_open;
  logic [7:0] pm_data  [spsc_pkg::PM_SEL_ENTRIES];
  logic [1:0] pm_scale [spsc_pkg::PM_SEL_ENTRIES];
  logic [7:0] sel_data;
  logic [1:0] sel_scale;

  // Captured slot power limit
  logic [7:0] cap_spl_value;
  logic [1:0] cap_spl_scale;

  // Link control and slot capability
  logic [1:0]                      aspm_ctl;
  logic [spsc_pkg::SCAP_WIDTH-1:0] slot_cap;
  logic                            dl_up_q;
  logic                            spl_trigger;

  // Slot power decode
  logic power_ctl_present;
  logic latch_sensor_present;
  logic latch_allows_power;
  logic slot_power_req;

  // Decoded access strobes
  logic ld_pm;
  logic ld_dcap;
  logic ld_scap;
  logic cfg_pm;
  logic cfg_lctl;
  logic [31:0] next_rdata;

  assign ld_pm    = LOAD_WR_I && (LOAD_ADDR_I == spsc_pkg::OFS_PM_DATA);
  assign ld_dcap  = LOAD_WR_I && (LOAD_ADDR_I == spsc_pkg::OFS_DEV_CAP);
  assign ld_scap  = LOAD_WR_I && (LOAD_ADDR_I == spsc_pkg::OFS_SLOT_CAP);
  assign cfg_pm   = CFG_WR_I && (CFG_ADDR_I == spsc_pkg::OFS_PM_DATA);
  assign cfg_lctl = CFG_WR_I && (CFG_ADDR_I == spsc_pkg::OFS_LINK_CTL);

  // The latch comes from an I/O expander pin, so it is sampled twice first
  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      latch_meta <= 1'b1;
      latch_sync <= 1'b1;
    end else begin
      latch_meta <= RETENTION_LATCH_I;
      latch_sync <= latch_meta;
    end
  end

  // Data selector: loader-only until the loader has written it once
  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      pm_sel      <= 4'h0;
      pm_sel_open <= 1'b0;
    end else if (ld_pm) begin
      pm_sel      <= LOAD_WDATA_I[spsc_pkg::PMD_SEL_LSB +: 4];
      pm_sel_open <= 1'b1;
    end else if (cfg_pm && pm_sel_open && CFG_BE_I[BE_SEL_LANE]) begin
      pm_sel      <= CFG_WDATA_I[spsc_pkg::PMD_SEL_LSB +: 4];
    end
  end

  // One data and scale entry per supported selector; config cannot write them
  generate
    for (genvar i = 0; i < spsc_pkg::PM_SEL_ENTRIES; i++) begin : g_pm
      always_ff @(posedge REF_CLK_I) begin
        if (!RESET_N_I) begin
          pm_data[i]  <= 8'h00;
          pm_scale[i] <= 2'h0;
        end else if (ld_pm &&
                     LOAD_WDATA_I[spsc_pkg::PMD_SEL_LSB +: 4] == spsc_pkg::PM_SEL_CODES[i]) begin
          pm_data[i]  <= LOAD_WDATA_I[spsc_pkg::PMD_DATA_LSB +: 8];
          pm_scale[i] <= LOAD_WDATA_I[spsc_pkg::PMD_SCL_LSB +: 2];
        end
      end
    end
  endgenerate

  // Unsupported selector codes return zero
  always_comb begin
    sel_data  = 8'h00;
    sel_scale = 2'h0;
    for (int i = 0; i < spsc_pkg::PM_SEL_ENTRIES; i++) begin
      if (pm_sel == spsc_pkg::PM_SEL_CODES[i]) begin
        sel_data  = pm_data[i];
        sel_scale = pm_scale[i];
      end
    end
  end

  // Captured limit follows received messages on upstream and NT ports only
  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      cap_spl_value <= 8'h00;
      cap_spl_scale <= 2'h0;
    end else if (ld_dcap) begin
      cap_spl_value <= LOAD_WDATA_I[spsc_pkg::DCAP_CSPL_VAL_LSB +: 8];
      cap_spl_scale <= LOAD_WDATA_I[spsc_pkg::DCAP_CSPL_SCL_LSB +: 2];
    end else if (SPL_RX_VALID_I && !IS_DOWN) begin
      cap_spl_value <= SPL_RX_VALUE_I;
      cap_spl_scale <= SPL_RX_SCALE_I;
    end
  end

  // ASPM control, written by configuration software
  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      aspm_ctl <= 2'h0;
    end else if (cfg_lctl && CFG_BE_I[BE_ASPM_LANE]) begin
      aspm_ctl <= CFG_WDATA_I[LCTL_ASPM_LSB +: 2];
    end
  end

  // Slot capability comes from the loader only; kept zero off downstream ports
  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      slot_cap <= '0;
    end else if (ld_scap && IS_DOWN) begin
      slot_cap <= LOAD_WDATA_I[spsc_pkg::SCAP_WIDTH-1:0];
    end
  end

  // Message on slot capability load and on each link-up edge, downstream ports only
  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      dl_up_q     <= 1'b0;
      spl_trigger <= 1'b0;
    end else begin
      dl_up_q     <= DL_UP_I;
      spl_trigger <= IS_DOWN && (ld_scap || (DL_UP_I && !dl_up_q));
    end
  end

  assign caps.nfts        = FAST_TRAINING_SEQ_COUNT_I;
  assign caps.speed_5g    = LINK_SPEED_5G_I;
  assign caps.spl_trigger = spl_trigger;
  assign caps.spl_value   = slot_cap[spsc_pkg::SCAP_SPL_VAL_LSB +: 8];
  assign caps.spl_scale   = slot_cap[spsc_pkg::SCAP_SPL_SCL_LSB +: 2];
  assign caps.msg_ack     = SPL_MSG_ACK_I;

  // Latency codes are registered, so they lag a speed change by one cycle
  spsc_exit_latency u_latency (
    .clk_i   (REF_CLK_I),
    .rst_n_i (RESET_N_I),
    .caps    (caps.latency)
  );

  // The sender keeps a trigger that lands while a message is still posted
  spsc_spl_msg u_msg (
    .clk_i   (REF_CLK_I),
    .rst_n_i (RESET_N_I),
    .caps    (caps.message)
  );

  assign SPL_MSG_REQ_O   = caps.msg_req;
  assign SPL_MSG_VALUE_O = caps.msg_value;
  assign SPL_MSG_SCALE_O = caps.msg_scale;

  // Read data; unmapped offsets and reserved bits read zero
  always_comb begin
    next_rdata = spsc_pkg::ZERO_WORD;
    unique case (CFG_ADDR_I)
      spsc_pkg::OFS_PM_DATA: begin
        next_rdata[spsc_pkg::PMD_DATA_LSB +: 8] = sel_data;
        next_rdata[spsc_pkg::PMD_SCL_LSB +: 2]  = sel_scale;
        next_rdata[spsc_pkg::PMD_SEL_LSB +: 4]  = pm_sel;
      end
      spsc_pkg::OFS_DEV_CAP: begin
        next_rdata[spsc_pkg::DCAP_CSPL_VAL_LSB +: 8] = cap_spl_value;
        next_rdata[spsc_pkg::DCAP_CSPL_SCL_LSB +: 2] = cap_spl_scale;
      end
      spsc_pkg::OFS_DEV_CTL: begin
        next_rdata = spsc_pkg::ZERO_WORD;
      end
      spsc_pkg::OFS_LINK_CAP: begin
        next_rdata[spsc_pkg::LCAP_ASPM_LSB +: 2] = ASPM_SUPPORT;
        next_rdata[spsc_pkg::LCAP_L0S_LSB +: 3]  = caps.l0s_code;
        next_rdata[spsc_pkg::LCAP_L1_LSB +: 3]   = caps.l1_code;
      end
      spsc_pkg::OFS_LINK_CTL: begin
        next_rdata[LCTL_ASPM_LSB +: 2] = aspm_ctl;
      end
      spsc_pkg::OFS_SLOT_CAP: begin
        if (IS_DOWN) begin
          next_rdata[spsc_pkg::SCAP_WIDTH-1:0] = slot_cap;
        end
      end
      default: begin
        next_rdata = spsc_pkg::ZERO_WORD;
      end
    endcase
  end

  // Data is zeroed outside reads so a stale word never looks like an answer
  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      CFG_RDATA_O  <= spsc_pkg::ZERO_WORD;
      CFG_RVALID_O <= 1'b0;
    end else begin
      CFG_RDATA_O  <= CFG_RD_I ? next_rdata : spsc_pkg::ZERO_WORD;
      CFG_RVALID_O <= CFG_RD_I;
    end
  end

  // Entry gates; a port that does not offer L1 never enables it
  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      TX_L0S_ENABLE_O <= 1'b0;
      L1_ENABLE_O     <= 1'b0;
    end else begin
      TX_L0S_ENABLE_O <= aspm_ctl[0];
      L1_ENABLE_O     <= aspm_ctl[1] && (ASPM_SUPPORT == spsc_pkg::ASPM_L0S_L1);
    end
  end

  // Fixed permissions; the receiver side of L0s is never gated
  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      RX_L0S_PERMIT_O    <= 1'b0;
      REFCLK_REMOVE_OK_O <= 1'b0;
    end else begin
      RX_L0S_PERMIT_O    <= 1'b1;
      REFCLK_REMOVE_OK_O <= 1'b0;
    end
  end

  // Without a latch sensor the latch position is a don't-care
  assign power_ctl_present    = slot_cap[spsc_pkg::SCAP_PWR_CTL_BIT];
  assign latch_sensor_present = slot_cap[spsc_pkg::SCAP_LATCH_BIT];
  assign latch_allows_power   = !latch_sensor_present || !latch_sync;
  assign slot_power_req       = power_ctl_present && !POWER_CONTROLLER_CONTROL_I
                                && latch_allows_power;

  // Hot-plug control lives only where a power controller exists
  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      HOTPLUG_ENABLE_O <= 1'b0;
    end else begin
      HOTPLUG_ENABLE_O <= power_ctl_present;
    end
  end

  // Slot power: needs a controller, control bit clear, and a closed latch if sensed
  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      SLOT_POWER_ON_O <= 1'b0;
    end else begin
      SLOT_POWER_ON_O <= slot_power_req;
    end
  end

endmodule

// *** core/spsc_pkg.sv ***
package spsc_pkg;
  typedef enum logic [1:0] {
    SPSC_ROLE_UP   = 2'b00,
    SPSC_ROLE_DOWN = 2'b01,
    SPSC_ROLE_NT   = 2'b10
  } spsc_role_type;
  typedef enum logic [0:0] {
    SPSC_MSG_IDLE = 1'b0,
    SPSC_MSG_SEND = 1'b1
  } spsc_msg_state_type;
  localparam logic [7:0] OFS_PM_DATA     = 8'h44;
  localparam logic [7:0] OFS_DEV_CAP     = 8'h6C;
  localparam logic [7:0] OFS_DEV_CTL     = 8'h70;
  localparam logic [7:0] OFS_LINK_CAP    = 8'h74;
  localparam logic [7:0] OFS_LINK_CTL    = 8'h78;
  localparam logic [7:0] OFS_SLOT_CAP    = 8'h7C;
  localparam int PMD_SEL_LSB  = 9;
  localparam int PMD_SCL_LSB  = 13;
  localparam int PMD_DATA_LSB = 24;
  localparam int DCAP_CSPL_VAL_LSB = 18;
  localparam int DCAP_CSPL_SCL_LSB = 26;
  localparam int LCAP_ASPM_LSB = 10;
  localparam int LCAP_L0S_LSB  = 12;
  localparam int LCAP_L1_LSB   = 15;
  localparam int SCAP_PWR_CTL_BIT = 1;
  localparam int SCAP_LATCH_BIT   = 2;
  localparam int SCAP_SPL_VAL_LSB = 7;
  localparam int SCAP_SPL_SCL_LSB = 15;
  localparam int SCAP_WIDTH       = 17;
  localparam int PM_SEL_ENTRIES   = 4;
  localparam logic [3:0] PM_SEL_CODES [PM_SEL_ENTRIES] = '{4'h0, 4'h3, 4'h4, 4'h7};
  localparam logic [1:0] ASPM_L0S_ONLY = 2'h1;
  localparam logic [1:0] ASPM_L0S_L1   = 2'h3;
  localparam logic [2:0] L1_LAT_5G0 = 3'h1;
  localparam logic [2:0] L1_LAT_2G5 = 3'h2;
  localparam int SYMBOLS_PER_FTS = 4;
  localparam int SYMBOL_NS_2G5   = 4;
  localparam int SYMBOL_NS_5G0   = 2;
  localparam int LAT_STEP_NS [7] = '{64, 128, 256, 512, 1000, 2000, 4000};
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
endpackage

// *** core/spsc_caps_if.sv ***
interface spsc_caps_if;
  logic [7:0] nfts;
  logic       speed_5g;
  logic [2:0] l0s_code;
  logic [2:0] l1_code;
  logic       spl_trigger;
  logic [7:0] spl_value;
  logic [1:0] spl_scale;
  logic       msg_ack;
  logic       msg_req;
  logic [7:0] msg_value;
  logic [1:0] msg_scale;
  modport core    (output nfts, speed_5g, spl_trigger, spl_value, spl_scale, msg_ack,
                   input l0s_code, l1_code, msg_req, msg_value, msg_scale);
  modport latency (input nfts, speed_5g, output l0s_code, l1_code);
  modport message (input spl_trigger, spl_value, spl_scale, msg_ack,
                   output msg_req, msg_value, msg_scale);
endinterface

// *** core/spsc_exit_latency.sv ***
module spsc_exit_latency (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Link facts in, codes out
  spsc_caps_if.latency caps
);
  logic [12:0] lat_ns;
  logic [2:0]  next_l0s_code;

  // Latency is FTS count times symbols per FTS times symbol time
  always_comb begin
    lat_ns = 13'(caps.nfts) * 13'(spsc_pkg::SYMBOLS_PER_FTS)
           * (caps.speed_5g ? 13'(spsc_pkg::SYMBOL_NS_5G0) : 13'(spsc_pkg::SYMBOL_NS_2G5));
    next_l0s_code = 3'h7;
    for (int i = 6; i >= 0; i--) begin
      if (lat_ns < 13'(spsc_pkg::LAT_STEP_NS[i])) begin
        next_l0s_code = 3'(i);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      caps.l0s_code <= 3'h0;
      caps.l1_code  <= 3'h0;
    end else begin
      caps.l0s_code <= next_l0s_code;
      caps.l1_code  <= caps.speed_5g ? spsc_pkg::L1_LAT_5G0 : spsc_pkg::L1_LAT_2G5;
    end
  end
endmodule

// *** core/spsc_spl_msg.sv ***
module spsc_spl_msg (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Trigger in, message request out
  spsc_caps_if.message caps
);
  spsc_pkg::spsc_msg_state_type state;
  logic                         pending;

  // A trigger during a send is kept so the newest limit still goes out
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state          <= spsc_pkg::SPSC_MSG_IDLE;
      pending        <= 1'b0;
      caps.msg_req   <= 1'b0;
      caps.msg_value <= 8'h00;
      caps.msg_scale <= 2'h0;
    end else begin
      unique case (state)
        spsc_pkg::SPSC_MSG_IDLE: begin
          if (caps.spl_trigger || pending) begin
            state          <= spsc_pkg::SPSC_MSG_SEND;
            pending        <= 1'b0;
            caps.msg_req   <= 1'b1;
            caps.msg_value <= caps.spl_value;
            caps.msg_scale <= caps.spl_scale;
          end
        end
        spsc_pkg::SPSC_MSG_SEND: begin
          if (caps.spl_trigger) begin
            pending <= 1'b1;
          end
          if (caps.msg_ack) begin
            state        <= spsc_pkg::SPSC_MSG_IDLE;
            caps.msg_req <= 1'b0;
          end
        end
      endcase
    end
  end
endmodule

// *** verification/spsc_monitor.sv ***
module spsc_monitor #(
  parameter spsc_pkg::spsc_role_type PORT_ROLE    = spsc_pkg::SPSC_ROLE_DOWN,
  parameter logic [1:0]              ASPM_SUPPORT = spsc_pkg::ASPM_L0S_L1
) (
  // Clock and reset
  input wire logic        REF_CLK_I,
  input wire logic        RESET_N_I,
  // Configuration access
  input wire logic        CFG_WR_I,
  input wire logic        CFG_RD_I,
  input wire logic [7:0]  CFG_ADDR_I,
  input wire logic [3:0]  CFG_BE_I,
  input wire logic [31:0] CFG_WDATA_I,
  input wire logic [31:0] CFG_RDATA_O,
  // Link and message
  input wire logic        LINK_SPEED_5G_I,
  input wire logic        DL_UP_I,
  input wire logic        SPL_MSG_REQ_O,
  input wire logic [7:0]  SPL_MSG_VALUE_O,
  input wire logic [1:0]  SPL_MSG_SCALE_O,
  input wire logic        SPL_MSG_ACK_I,
  // Power outputs
  input wire logic        TX_L0S_ENABLE_O,
  input wire logic        L1_ENABLE_O,
  input wire logic        RX_L0S_PERMIT_O,
  input wire logic        REFCLK_REMOVE_OK_O,
  input wire logic        HOTPLUG_ENABLE_O,
  input wire logic        SLOT_POWER_ON_O
);
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!RESET_N_I);

  property p_pm_rsvd;
    CFG_RD_I && CFG_ADDR_I == 8'h44 |=> CFG_RDATA_O[23:22] == 2'h0;
  endproperty
  a_pm_rsvd: assert property (p_pm_rsvd)
    else $error("pm reserved bits not zero");
  property p_lat_zero;
    CFG_RD_I && CFG_ADDR_I == 8'h6C |=> CFG_RDATA_O[11:6] == 6'h00;
  endproperty
  a_lat_zero: assert property (p_lat_zero)
    else $error("acceptable latency not zero");
  property p_aspm_sup;
    CFG_RD_I && CFG_ADDR_I == 8'h74 |=> CFG_RDATA_O[11:10] == ASPM_SUPPORT;
  endproperty
  a_aspm_sup: assert property (p_aspm_sup)
    else $error("aspm support code wrong");
  // Speed held over two edges, so the code has settled before the read
  property p_l1_code;
    CFG_RD_I && CFG_ADDR_I == 8'h74 && $stable(LINK_SPEED_5G_I)
      |=> CFG_RDATA_O[17:15] == ($past(LINK_SPEED_5G_I) ? 3'h1 : 3'h2);
  endproperty
  a_l1_code: assert property (p_l1_code)
    else $error("l1 exit code wrong");
  property p_aspm_ctl;
    CFG_WR_I && CFG_ADDR_I == 8'h78 && CFG_BE_I[0] |-> ##2
      TX_L0S_ENABLE_O == $past(CFG_WDATA_I[0], 2) &&
      L1_ENABLE_O == ($past(CFG_WDATA_I[1], 2) && ASPM_SUPPORT == 2'h3);
  endproperty
  a_aspm_ctl: assert property (p_aspm_ctl)
    else $error("aspm enables do not follow control");
  property p_rx_l0s;
    $past(RESET_N_I) |-> RX_L0S_PERMIT_O;
  endproperty
  a_rx_l0s: assert property (p_rx_l0s)
    else $error("receiver l0s not permitted");
  property p_refclk;
    REFCLK_REMOVE_OK_O == 1'h0;
  endproperty
  a_refclk: assert property (p_refclk)
    else $error("reference clock removal allowed");
  property p_no_hp;
    !HOTPLUG_ENABLE_O |-> !SLOT_POWER_ON_O;
  endproperty
  a_no_hp: assert property (p_no_hp)
    else $error("slot powered without controller");
  property p_msg_hold;
    SPL_MSG_REQ_O && !SPL_MSG_ACK_I
      |=> SPL_MSG_REQ_O && $stable({SPL_MSG_SCALE_O, SPL_MSG_VALUE_O});
  endproperty
  a_msg_hold: assert property (p_msg_hold)
    else $error("message request not held");
  property p_dl_up;
    $rose(DL_UP_I) && PORT_ROLE == spsc_pkg::SPSC_ROLE_DOWN |-> ##[1:6] SPL_MSG_REQ_O;
  endproperty
  a_dl_up: assert property (p_dl_up)
    else $error("no message after link up");
endmodule

// *** verification/spsc_msg_sink.sv ***
module spsc_msg_sink (
  // Clock and message handshake
  input  wire logic       clk_i,
  input  wire logic       req_i,
  input  wire logic [7:0] value_i,
  input  wire logic [1:0] scale_i,
  input  wire logic [3:0] delay_i,
  output logic            ack_o,
  // Record of messages taken
  output int              count_o,
  output logic [9:0]      last_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_cnt = 4'h0;
  initial begin
    ack_o = 1'h0;
    count_o = 0;
    last_o = 10'h000;
  end
  // Ack pulses one cycle; a gap after it avoids taking a dropped request twice
  always @(negedge clk_i) begin
    if (ack_o) begin
      ack_o <= 1'h0;
    end else if (req_i && wait_cnt == delay_i) begin
      ack_o <= 1'h1;
      count_o <= count_o + 1;
      last_o <= {scale_i, value_i};
      wait_cnt <= 4'h0;
    end else if (req_i) begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule

// *** verification/testbench.sv ***
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0, rst_n = 1'h0, wr = 1'h0, rd = 1'h0, ld = 1'h0, dl_up = 1'h0;
  logic spd = 1'h0, rxv = 1'h0, latch = 1'h1, pcc = 1'h0, rvalid, req, ack;
  logic tx_l0s, l1, rx_l0s, refclk_ok, hp, slot_on;
  logic [7:0] addr = 8'h00, ld_addr = 8'h00, nfts = 8'h00, rx_val = 8'h00, mval;
  logic [1:0] rx_scl = 2'h0, mscl;
  logic [3:0] be = 4'h0, dly = 4'h0;
  logic [9:0] last;
  logic [31:0] wdata = 32'h0, ld_data = 32'h0, rdata;
  logic [7:0] ft [5] = '{8'h00, 8'h3F, 8'h40, 8'h40, 8'hFF};
  logic sp [5] = '{1'h1, 1'h1, 1'h1, 1'h0, 1'h0};
  logic [16:0] caps [5] = '{17'h0_CCFF, 17'h0_CCFF, 17'h0_CCFF, 17'h1_FFFD, 17'h0_0083};
  logic lat [5] = '{1'h0, 1'h1, 1'h0, 1'h0, 1'h1};
  logic ctl [5] = '{1'h0, 1'h0, 1'h1, 1'h0, 1'h0};
  int err_total = 0, n_checks = 0, sink_cnt, cnt0, ns, code;

  always #5 clk = ~clk;

  spsc_top #(.PORT_ROLE(spsc_pkg::SPSC_ROLE_DOWN), .ASPM_SUPPORT(2'h3)) u_dut (
    .REF_CLK_I(clk), .RESET_N_I(rst_n), .CFG_WR_I(wr), .CFG_RD_I(rd),
    .CFG_ADDR_I(addr), .CFG_BE_I(be), .CFG_WDATA_I(wdata), .CFG_RDATA_O(rdata),
    .CFG_RVALID_O(rvalid), .LOAD_WR_I(ld), .LOAD_ADDR_I(ld_addr), .LOAD_WDATA_I(ld_data),
    .FAST_TRAINING_SEQ_COUNT_I(nfts), .LINK_SPEED_5G_I(spd), .DL_UP_I(dl_up),
    .SPL_RX_VALID_I(rxv), .SPL_RX_VALUE_I(rx_val), .SPL_RX_SCALE_I(rx_scl),
    .SPL_MSG_REQ_O(req), .SPL_MSG_VALUE_O(mval), .SPL_MSG_SCALE_O(mscl),
    .SPL_MSG_ACK_I(ack), .RETENTION_LATCH_I(latch), .POWER_CONTROLLER_CONTROL_I(pcc),
    .TX_L0S_ENABLE_O(tx_l0s), .L1_ENABLE_O(l1), .RX_L0S_PERMIT_O(rx_l0s),
    .REFCLK_REMOVE_OK_O(refclk_ok), .HOTPLUG_ENABLE_O(hp), .SLOT_POWER_ON_O(slot_on));

  spsc_msg_sink u_sink (.clk_i(clk), .req_i(req), .value_i(mval), .scale_i(mscl),
    .delay_i(dly), .ack_o(ack), .count_o(sink_cnt), .last_o(last));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cfg_wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    @(negedge clk);
    wr = 1'h1;
    addr = a;
    be = b;
    wdata = d;
    @(negedge clk);
    wr = 1'h0;
  endtask
  task automatic ld_wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    ld = 1'h1;
    ld_addr = a;
    ld_data = d;
    @(negedge clk);
    ld = 1'h0;
  endtask
  task automatic rd_chk(string what, logic [7:0] a, logic [31:0] m, logic [31:0] exp);
    @(negedge clk);
    rd = 1'h1;
    addr = a;
    @(negedge clk);
    rd = 1'h0;
    chk("read answer", 32'h1, {31'h0, rvalid});
    chk(what, exp, rdata & m);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1'h1;
    rd_chk("pm data", 8'h44, 32'hFFFF_FE00, 32'h0);
    // Select stays locked until a loader write has reached the register
    cfg_wr(8'h44, 4'h2, 32'h0000_0600);
    rd_chk("pm select", 8'h44, 32'h0000_1E00, 32'h0);
    for (int i = 0; i < spsc_pkg::PM_SEL_ENTRIES; i++) begin
      ld_wr(8'h44, {8'hA0 + 8'(i), 9'h0, 2'(i), spsc_pkg::PM_SEL_CODES[i], 9'h0});
    end
    ld_wr(8'h44, {8'hEE, 9'h0, 2'h3, 4'h5, 9'h0});
    rd_chk("pm reserved select", 8'h44, 32'hFFFF_FE00, 32'h0000_0A00);
    for (int i = 0; i < spsc_pkg::PM_SEL_ENTRIES; i++) begin
      cfg_wr(8'h44, 4'h2, {19'h0, spsc_pkg::PM_SEL_CODES[i], 9'h0});
      rd_chk("pm entry", 8'h44, 32'hFFFF_FE00,
             {8'hA0 + 8'(i), 9'h0, 2'(i), spsc_pkg::PM_SEL_CODES[i], 9'h0});
    end
    for (int s = 0; s < 4; s++) begin
      ld_wr(8'h6C, {4'h0, 2'(s), 8'h30 + 8'(s), 12'h03F, 6'h0});
      rd_chk("captured limit", 8'h6C, 32'h0FFF_FFC0, {4'h0, 2'(s), 8'h30 + 8'(s), 18'h0});
    end
    cfg_wr(8'h6C, 4'hF, 32'h0);
    rd_chk("captured read only", 8'h6C, 32'h0FFF_FFC0, 32'h0CCC_0000);
    for (int i = 0; i < 5; i++) begin
      nfts = ft[i];
      spd = sp[i];
      ns = int'(nfts) * spsc_pkg::SYMBOLS_PER_FTS * (spd ? 2 : 4);
      code = 0;
      for (int k = 0; k < 7; k++) begin
        if (ns >= spsc_pkg::LAT_STEP_NS[k]) code = k + 1;
      end
      repeat (2) @(negedge clk);
      rd_chk("link caps", 8'h74, 32'h0003_FC00,
             {14'h0, spd ? 3'h1 : 3'h2, 3'(code), 2'h3, 10'h0});
    end
    for (int a = 0; a < 4; a++) begin
      cfg_wr(8'h78, 4'h3, {23'h0, 1'h1, 6'h0, 2'(a)});
      repeat (2) @(negedge clk);
      chk("tx l0s", 32'(a & 1), {31'h0, tx_l0s});
      chk("l1", 32'(a >> 1), {31'h0, l1});
      chk("refclk", 32'h0, {31'h0, refclk_ok});
      chk("rx l0s", 32'h1, {31'h0, rx_l0s});
      rd_chk("link control", 8'h78, 32'h0000_0103, 32'(a));
    end
    // Prompt partner first, then a slow one that keeps the request posted
    for (int i = 0; i < 5; i++) begin
      dly = (i > 2) ? 4'h9 : 4'h0;
      latch = lat[i];
      pcc = ctl[i];
      cnt0 = sink_cnt;
      ld_wr(8'h7C, {15'h0, caps[i]});
      for (int w = 0; w < 40 && sink_cnt == cnt0; w++) @(negedge clk);
      chk("messages", 32'(cnt0 + 1), 32'(sink_cnt));
      chk("message body", {22'h0, caps[i][16:7]}, {22'h0, last});
      chk("hotplug", {31'h0, caps[i][1]}, {31'h0, hp});
      chk("slot power", {31'h0, caps[i][1] & !ctl[i] & (!caps[i][2] | !lat[i])},
          {31'h0, slot_on});
      rd_chk("slot caps", 8'h7C, 32'h0001_FFFF, {15'h0, caps[i]});
    end
    cfg_wr(8'h7C, 4'hF, 32'h0);
    rd_chk("slot read only", 8'h7C, 32'h0001_FFFF, {15'h0, caps[4]});
    cnt0 = sink_cnt;
    dl_up = 1'h1;
    for (int w = 0; w < 40 && sink_cnt == cnt0; w++) @(negedge clk);
    chk("link up message", 32'(cnt0 + 1), 32'(sink_cnt));
    tally_and_finish;
  end

  // Whole run needs well under 3000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    tally_and_finish;
  end
endmodule

bind spsc_top spsc_monitor #(.PORT_ROLE(PORT_ROLE), .ASPM_SUPPORT(ASPM_SUPPORT)) u_mon (.*);
